// ===== rtl/srw_top.sv
// Supervisor: reset stretcher, watchdog and chip-enable gate
`timescale 1ns/1ns
module srw_top
   import srw_pkg::*;
#(
   parameter int unsigned P_RESET_HOLD_CYC = RESET_HOLD_CYC,
   parameter longint unsigned P_WD_DEFAULT_CYC = WD_DEFAULT_CYC,
   parameter int unsigned P_WD_PER_NF_CYC = WD_PER_NF_CYC,
   parameter int unsigned P_WARN_PULSE_CYC = WARN_PULSE_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_supply_ok,
   input wire logic i_early_supply_warn_n_ok,
   input wire logic i_power_fail_sense_in,
   input wire logic i_manual_reset_n,
   input wire logic i_backup_select,
   input wire logic i_timeout_select_in,
   input wire logic [CAP_W-1:0] i_timing_cap_nf,
   input wire logic [1:0] i_watchdog_kick_in,
   input wire logic i_chip_enable_n,
   output logic o_reset_n,
   output logic o_power_fail_flag_n,
   output logic o_early_supply_warn_n,
   output logic o_watchdog_fault_n,
   output logic o_watchdog_warn_pulse_n,
   output logic o_chip_enable_out_n,
   output logic o_backup_active,
   output logic o_kick_bias_en
);
   // Three-stage synchronisers for all pin inputs except i_timing_cap_nf
   logic [2:0] sup_s_q, ll_s_q, pf_s_q, mr_s_q, bk_s_q, ts_s_q, ce_s_q;
   logic [1:0] kk0_s_q [3];
   logic sup_q, ll_q, pf_q, mr_q, bk_q, ts_q, ce_q;
   logic [1:0] kick_q;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sup_s_q <= 3'h0;
         ll_s_q <= 3'h0;
         pf_s_q <= 3'h7;
         mr_s_q <= 3'h7;
         bk_s_q <= 3'h0;
         ts_s_q <= 3'h7;
         ce_s_q <= 3'h7;
         kk0_s_q <= '{default: KICK_OPEN};
      end else begin
         sup_s_q <= {sup_s_q[1:0], i_supply_ok};
         ll_s_q <= {ll_s_q[1:0], i_early_supply_warn_n_ok};
         pf_s_q <= {pf_s_q[1:0], i_power_fail_sense_in};
         mr_s_q <= {mr_s_q[1:0], i_manual_reset_n};
         bk_s_q <= {bk_s_q[1:0], i_backup_select};
         ts_s_q <= {ts_s_q[1:0], i_timeout_select_in};
         ce_s_q <= {ce_s_q[1:0], i_chip_enable_n};
         kk0_s_q <= '{i_watchdog_kick_in, kk0_s_q[0], kk0_s_q[1]};
      end
   end

   // A level counts once stages two and three agree
   wire sup_agree = sup_s_q[1] == sup_s_q[2];
   wire ll_agree = ll_s_q[1] == ll_s_q[2];
   wire pf_agree = pf_s_q[1] == pf_s_q[2];
   wire mr_agree = mr_s_q[1] == mr_s_q[2];
   wire bk_agree = bk_s_q[1] == bk_s_q[2];
   wire ts_agree = ts_s_q[1] == ts_s_q[2];
   wire ce_agree = ce_s_q[1] == ce_s_q[2];
   wire kk_agree = kk0_s_q[1] == kk0_s_q[2];

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sup_q <= 1'b0;
         ll_q <= 1'b0;
         pf_q <= 1'b1;
         mr_q <= 1'b1;
         bk_q <= 1'b0;
         ts_q <= 1'b1;
         ce_q <= 1'b1;
         kick_q <= KICK_OPEN;
      end else begin
         if (sup_agree) sup_q <= sup_s_q[2];
         if (ll_agree) ll_q <= ll_s_q[2];
         if (pf_agree) pf_q <= pf_s_q[2];
         if (mr_agree) mr_q <= mr_s_q[2];
         if (bk_agree) bk_q <= bk_s_q[2];
         if (ts_agree) ts_q <= ts_s_q[2];
         if (ce_agree) ce_q <= ce_s_q[2];
         if (kk_agree) kick_q <= kk0_s_q[2];
      end
   end

   // Manual reset: assertion delay and long-pulse detection
   logic [CNT_W-1:0] mr_low_cnt_q, mr_low_cnt_d;
   logic mr_active_q, mr_clear_q;
   wire mr_low = ~mr_q;
   assign mr_low_cnt_d = mr_low ? ((mr_low_cnt_q == '1) ? mr_low_cnt_q
                                   : mr_low_cnt_q + 1'b1) : '0;
   // Once asserted after the delay, reset stays asserted for the rest of the low phase
   wire mr_active_d = mr_low && (mr_low_cnt_q >= CNT_W'(MR_DELAY_CYC - 1));

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         mr_low_cnt_q <= '0;
         mr_active_q <= 1'b0;
         mr_clear_q <= 1'b0;
      end else begin
         mr_low_cnt_q <= mr_low_cnt_d;
         mr_active_q <= mr_active_d;
         // Long pulse clears counters; held until the button is released
         if (mr_low && mr_low_cnt_q >= CNT_W'(MR_CLEAR_CYC - 1))
            mr_clear_q <= 1'b1;
         else if (!mr_low)
            mr_clear_q <= 1'b0;
      end
   end

   // Reset stretcher; battery switchover plays no part here
   wire rst_cause = !sup_q || mr_active_q;
   logic [CNT_W-1:0] rst_cnt_q;
   logic rst_n_q;
   wire rst_done = rst_cnt_q >= CNT_W'(P_RESET_HOLD_CYC - 1);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rst_cnt_q <= '0;
         rst_n_q <= 1'b0;
      end else if (rst_cause) begin
         rst_cnt_q <= '0;
         rst_n_q <= 1'b0;
      end else if (!rst_n_q) begin
         rst_cnt_q <= rst_done ? rst_cnt_q : rst_cnt_q + 1'b1;
         rst_n_q <= rst_done;
      end
   end
   assign o_reset_n = rst_n_q;

   // Comparator outputs; power-fail is independent of all else
   logic pf_n_q, ll_n_q, bk_on_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pf_n_q <= 1'b1;
         ll_n_q <= 1'b0;
         bk_on_q <= 1'b0;
      end else begin
         pf_n_q <= pf_q;
         ll_n_q <= ll_q;
         bk_on_q <= bk_q;
      end
   end
   assign o_power_fail_flag_n = pf_n_q;
   assign o_early_supply_warn_n = ll_n_q;
   assign o_backup_active = bk_on_q;
   // Bias released under low supply, so the input floats
   assign o_kick_bias_en = sup_q;

   // Watchdog
   logic [1:0] kick_prev_q;
   wire kick_open = kick_q == KICK_OPEN;
   wire kick_change = kick_q != kick_prev_q;
   // Any change to a level other than open counts, with no pulse-width check
   wire kick_event = !kick_open && kick_change;
   wire wd_off = !sup_q || bk_q || kick_open || !rst_n_q || mr_clear_q;
   wire [CNT_W-1:0] cap_period = CNT_W'(i_timing_cap_nf) *
      CNT_W'(P_WD_PER_NF_CYC);
   wire [CNT_W-1:0] wd_period = ts_q ? CNT_W'(P_WD_DEFAULT_CYC)
      : cap_period;
   srw_wd_state_t wd_state_q, wd_state_d;
   logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d, warn_cnt_q, lag_cnt_q;
   logic fault_n_q, warn_n_q, lag_run_q;
   wire wd_expire = wd_cnt_q >= wd_period - 1'b1;
   wire wd_running = wd_state_q == SRW_WD_RUN;
   wire wd_warning = wd_state_q == SRW_WD_WARN;
   // A kick in the expiry cycle wins, so no pulse follows it
   wire wd_fire = wd_running && wd_expire && !kick_event;
   wire warn_done = warn_cnt_q >= CNT_W'(P_WARN_PULSE_CYC - 1);
   wire lag_done = lag_cnt_q >= CNT_W'(FAULT_LAG_CYC - 1);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         kick_prev_q <= KICK_OPEN;
      end else begin
         kick_prev_q <= kick_q;
      end
   end

   // Period counter keeps running through the warning pulse
   always_comb begin
      wd_state_d = wd_state_q;
      wd_cnt_d = wd_cnt_q + 1'b1;
      case (wd_state_q)
         SRW_WD_IDLE: begin
            wd_cnt_d = '0;
            wd_state_d = SRW_WD_RUN;
         end
         SRW_WD_RUN: begin
            if (kick_event || wd_expire) wd_cnt_d = '0;
            if (wd_fire) wd_state_d = SRW_WD_WARN;
         end
         SRW_WD_WARN: begin
            if (kick_event) wd_cnt_d = '0;
            if (warn_done) wd_state_d = SRW_WD_RUN;
         end
         default: begin
            wd_cnt_d = '0;
            wd_state_d = SRW_WD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wd_state_q <= SRW_WD_IDLE;
         wd_cnt_q <= '0;
      end else if (wd_off) begin
         wd_state_q <= SRW_WD_IDLE;
         wd_cnt_q <= '0;
      end else begin
         wd_state_q <= wd_state_d;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         warn_cnt_q <= '0;
         warn_n_q <= 1'b1;
      end else if (wd_off) begin
         warn_cnt_q <= '0;
         warn_n_q <= 1'b1;
      end else if (wd_fire) begin
         warn_cnt_q <= '0;
         warn_n_q <= 1'b0;
      end else if (wd_warning) begin
         warn_cnt_q <= warn_cnt_q + 1'b1;
         if (warn_done) warn_n_q <= 1'b1;
      end
   end

   // Fault only follows the first expiry; a repeat leaves it low
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         lag_cnt_q <= '0;
         lag_run_q <= 1'b0;
         fault_n_q <= 1'b1;
      end else if (wd_off) begin
         lag_cnt_q <= '0;
         lag_run_q <= 1'b0;
         fault_n_q <= 1'b1;
      end else if (kick_event) begin
         lag_run_q <= 1'b0;
         fault_n_q <= 1'b1;
      end else if (wd_fire) begin
         lag_cnt_q <= '0;
         lag_run_q <= fault_n_q;
      end else if (lag_run_q) begin
         lag_cnt_q <= lag_cnt_q + 1'b1;
         if (lag_done) begin
            fault_n_q <= 1'b0;
            lag_run_q <= 1'b0;
         end
      end
   end
   assign o_watchdog_fault_n = fault_n_q;
   assign o_watchdog_warn_pulse_n = warn_n_q;

   // Chip-enable gate: open outside reset and for a short hold into it
   logic ce_hold_q;
   logic [CNT_W-1:0] ce_cnt_q;
   logic ce_out_n_q;
   // Fall taken on the edge that drops reset, so the gate never blinks
   wire rst_fall = rst_n_q && rst_cause;
   wire ce_hold_end = ce_q || ce_cnt_q >= CNT_W'(CE_HOLD_CYC - 1);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ce_hold_q <= 1'b0;
         ce_cnt_q <= '0;
         ce_out_n_q <= 1'b1;
      end else begin
         if (mr_clear_q) begin
            ce_hold_q <= 1'b0;
         end else if (rst_fall && !ce_q) begin
            ce_hold_q <= 1'b1;
            ce_cnt_q <= '0;
         end else if (ce_hold_q) begin
            ce_cnt_q <= ce_cnt_q + 1'b1;
            if (ce_hold_end) ce_hold_q <= 1'b0;
         end
         // Power-up reset keeps the path shut
         if (rst_n_q)
            ce_out_n_q <= ce_q;
         else
            ce_out_n_q <= !(ce_hold_q && !ce_q && !mr_clear_q);
      end
   end
   assign o_chip_enable_out_n = ce_out_n_q;

endmodule

// ===== rtl/srw_pkg.sv
// Constants for the supervisor reset and watchdog block
package srw_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned RESET_HOLD_MS = 200;
   localparam int unsigned WD_DEFAULT_MS = 1600;
   localparam int unsigned WD_PER_NF_US = 2100;
   localparam int unsigned MR_DELAY_US = 4;
   localparam int unsigned MR_CLEAR_US = 15;
   localparam int unsigned CE_HOLD_US = 15;
   localparam int unsigned WARN_PULSE_MS = 1;
   localparam int unsigned FAULT_LAG_NS = 70;
   localparam int unsigned KICK_PULSE_NS = 100;
   // Longest times round down, least times round up
   localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
   localparam longint unsigned WD_DEFAULT_CYC =
      64'(WD_DEFAULT_MS) * 64'(CLK_HZ / 1000);
   localparam int unsigned WD_PER_NF_CYC = WD_PER_NF_US * (CLK_HZ / 1000000);
   localparam int unsigned MR_DELAY_CYC = MR_DELAY_US * (CLK_HZ / 1000000);
   localparam int unsigned MR_CLEAR_CYC = MR_CLEAR_US * (CLK_HZ / 1000000);
   localparam int unsigned CE_HOLD_CYC = CE_HOLD_US * (CLK_HZ / 1000000);
   localparam int unsigned WARN_PULSE_CYC = WARN_PULSE_MS * (CLK_HZ / 1000);
   localparam int unsigned FAULT_LAG_CYC = (FAULT_LAG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned KICK_PULSE_CYC =
      (KICK_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned CAP_W = 8;
   // Kick input levels from the three-level comparators
   localparam logic [1:0] KICK_LOW = 2'h0;
   localparam logic [1:0] KICK_HIGH = 2'h1;
   localparam logic [1:0] KICK_OPEN = 2'h2;
   typedef enum logic [1:0] {
      SRW_WD_IDLE,
      SRW_WD_RUN,
      SRW_WD_WARN
   } srw_wd_state_t;
endpackage

// ===== testbench/srw_chk_asserts.sv
// Assertion checker for the supervisor block
`timescale 1ns/1ns
module srw_chk
   import srw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_supply_ok,
   input wire logic i_power_fail_sense_in,
   input wire logic i_manual_reset_n,
   input wire logic [1:0] i_watchdog_kick_in,
   input wire logic i_chip_enable_n,
   input wire logic o_reset_n,
   input wire logic o_power_fail_flag_n,
   input wire logic o_watchdog_fault_n,
   input wire logic o_watchdog_warn_pulse_n,
   input wire logic o_chip_enable_out_n,
   input wire logic o_kick_bias_en
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   logic [11:0] ce_q;
   // Cycles the gate stays open while reset is asserted
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ce_q <= 12'h0;
      end else begin
         ce_q <= (!o_reset_n && !o_chip_enable_out_n) ? ce_q + 12'h1 : 12'h0;
      end
   end
   AST_PF_FOLLOW: assert property ($changed(i_power_fail_sense_in) |->
      ##[1:8] o_power_fail_flag_n == i_power_fail_sense_in) else $error("pf");
   AST_RST_FALL: assert property ($fell(i_supply_ok) |->
      ##[1:8] !o_reset_n) else $error("reset late");
   AST_RST_REL: assert property ($rose(o_reset_n) |->
      $past(i_supply_ok, 8) && $past(i_manual_reset_n, 8)) else $error("rel");
   AST_CE_REL: assert property ($rose(i_chip_enable_n) |->
      ##[1:8] o_chip_enable_out_n) else $error("ce stuck");
   AST_CE_HOLD: assert property (ce_q <= 12'(CE_HOLD_CYC + 8))
      else $error("ce hold");
   AST_CE_KEEP: assert property ($fell(o_reset_n) &&
      !o_chip_enable_out_n && !i_chip_enable_n |=> !o_chip_enable_out_n)
      else $error("ce blink");
   AST_WARN_W: assert property ($fell(o_watchdog_warn_pulse_n) |->
      !o_watchdog_warn_pulse_n[*8]) else $error("warn short");
   AST_FAULT_LAG: assert property ($fell(o_watchdog_fault_n) |->
      !$past(o_watchdog_warn_pulse_n, FAULT_LAG_CYC) &&
      $past(o_watchdog_warn_pulse_n, FAULT_LAG_CYC + 1)) else $error("lag");
   AST_FAULT_REL: assert property (!o_watchdog_fault_n &&
      $changed(i_watchdog_kick_in) |-> ##[1:8] o_watchdog_fault_n)
      else $error("fault stuck");
   AST_WD_OFF: assert property (!o_reset_n[*4] |->
      o_watchdog_fault_n && o_watchdog_warn_pulse_n) else $error("wd on");
   AST_BIAS_OFF: assert property ($fell(i_supply_ok) |->
      ##[1:8] !o_kick_bias_en) else $error("bias on");
   COV_WARN: cover property ($fell(o_watchdog_warn_pulse_n));
   COV_FAULT: cover property ($fell(o_watchdog_fault_n));
   COV_REL: cover property ($rose(o_reset_n));
endmodule
bind srw_top srw_chk srw_chk_i (.i_clk(i_clk), .i_reset(i_reset),
   .i_supply_ok(i_supply_ok), .i_power_fail_sense_in(i_power_fail_sense_in),
   .i_manual_reset_n(i_manual_reset_n), .i_chip_enable_n(i_chip_enable_n),
   .i_watchdog_kick_in(i_watchdog_kick_in), .o_reset_n(o_reset_n),
   .o_power_fail_flag_n(o_power_fail_flag_n),
   .o_watchdog_fault_n(o_watchdog_fault_n),
   .o_watchdog_warn_pulse_n(o_watchdog_warn_pulse_n),
   .o_chip_enable_out_n(o_chip_enable_out_n),
   .o_kick_bias_en(o_kick_bias_en));

// ===== testbench/srw_cpu_model.sv
// Processor model: refreshes the watchdog and drives memory enable
`timescale 1ns/1ns
module srw_cpu_model
   import srw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_run_n,
   input wire logic i_kick_en,
   input wire logic i_float,
   input wire logic i_ce_req_n,
   output logic [1:0] o_kick,
   output logic o_ce_n
);
   logic lvl_q = 1'b0;
   logic [4:0] cnt_q = 5'h0;
   // Stalled in reset, so no refresh then
   always_ff @(posedge i_clk) begin
      cnt_q <= cnt_q + 5'h1;
      if (i_kick_en && i_run_n && cnt_q == 5'h1f) begin
         lvl_q <= ~lvl_q;
      end
   end
   assign o_kick = i_float ? KICK_OPEN : (lvl_q ? KICK_HIGH : KICK_LOW);
   assign o_ce_n = i_ce_req_n;
endmodule

// ===== testbench/srw_top_tb.sv
// Self-checking bench for the supervisor block
`timescale 1ns/1ns
module srw_top_tb;
   import srw_pkg::*;
   logic clk, rst, sup, ll, pf, mr_n, bk, tsel, ce_req_n, kick_en, flt;
   logic ce_n, rst_n, pf_n, ll_n, fault_n, warn_n, ce_o_n, bk_act, bias;
   logic [7:0] cap;
   logic [1:0] kick;
   logic [3:0] rows [5] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h6};
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   srw_top #(.P_RESET_HOLD_CYC(50), .P_WD_DEFAULT_CYC(200),
      .P_WD_PER_NF_CYC(10), .P_WARN_PULSE_CYC(8)) srw_top_i (
      .i_clk(clk), .i_reset(rst), .i_supply_ok(sup), .i_early_supply_warn_n_ok(ll),
      .i_power_fail_sense_in(pf), .i_manual_reset_n(mr_n),
      .i_backup_select(bk), .i_timeout_select_in(tsel),
      .i_timing_cap_nf(cap), .i_watchdog_kick_in(kick),
      .i_chip_enable_n(ce_n), .o_reset_n(rst_n), .o_power_fail_flag_n(pf_n),
      .o_early_supply_warn_n(ll_n), .o_watchdog_fault_n(fault_n),
      .o_watchdog_warn_pulse_n(warn_n), .o_chip_enable_out_n(ce_o_n),
      .o_backup_active(bk_act), .o_kick_bias_en(bias));
   srw_cpu_model srw_cpu_model_i (.i_clk(clk), .i_run_n(rst_n),
      .i_kick_en(kick_en), .i_float(flt), .i_ce_req_n(ce_req_n),
      .o_kick(kick), .o_ce_n(ce_n));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input int lim,
      output int k);
      k = 0;
      while (s !== v && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Stop refreshing just after a refresh, then time the expiry
   task automatic expire(input int p);
      int k;
      @(kick);
      #1;
      kick_en = 0;
      wait_lvl(warn_n, 0, 400, k);
      chk("period", k >= p && k <= p + 10, 1);
      wait_lvl(fault_n, 0, 20, k);
      chk("fault lag", k, FAULT_LAG_CYC);
      wait_lvl(warn_n, 1, 20, k);
      wait_lvl(warn_n, 0, 400, k);
      chk("repeat", {warn_n, fault_n}, 2'h0);
      kick_en = 1;
      wait_lvl(fault_n, 1, 60, k);
      chk("release", k < 48, 1);
      $display("Test done: expiry");
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      // rst sup ll pf mr_n bk tsel ce_req_n kick_en flt
      {rst, sup, ll, pf, mr_n, bk, tsel, ce_req_n, kick_en, flt} = 10'h3e8;
      cap = 8'h05;
      repeat (5) @(posedge clk);
      #1;
      chk("reset values", {rst_n, fault_n, warn_n, ce_o_n, pf_n, ll_n,
         bk_act, bias}, 8'h78);
      repeat (5) @(posedge clk);
      #1;
      rst = 0;
      wait_lvl(rst_n, 1, 200, n);
      chk("power-up hold", n >= 50 && n <= 62, 1);
      chk("gate closed", ce_o_n, 1);
      $display("Test done: power-up");
      kick_en = 1;
      foreach (rows[i]) begin
         {pf, ll, bk, ce_req_n} = rows[i];
         repeat (12) @(posedge clk);
         #1;
         chk("levels", {pf_n, ll_n, bk_act, ce_o_n}, rows[i]);
         chk("backup no reset", rst_n, 1);
      end
      {pf, ll, bk, ce_req_n} = 4'hc;
      $display("Test done: rows");
      for (int i = 0; i < 2; i++) begin
         tsel = (i == 0);
         expire(i == 0 ? 200 : 50);
      end
      kick_en = 0;
      flt = 1;
      wait_lvl(warn_n, 0, 300, n);
      chk("open kick", n, 300);
      chk("open fault", fault_n, 1);
      flt = 0;
      {sup, ll} = 2'h0;
      wait_lvl(rst_n, 0, 20, n);
      chk("brownout", n <= 8, 1);
      repeat (4) @(posedge clk);
      #1;
      chk("bias off", bias, 0);
      wait_lvl(ce_o_n, 1, 2000, n);
      chk("gate hold", n + 16 >= CE_HOLD_CYC && n <= CE_HOLD_CYC + 4, 1);
      {sup, ll} = 2'h3;
      wait_lvl(rst_n, 1, 200, n);
      chk("recovery", n >= 50 && n <= 62, 1);
      wait_lvl(warn_n, 0, 200, n);
      chk("fresh period", n >= 48 && n <= 60, 1);
      chk("gate open", ce_o_n, 0);
      kick_en = 1;
      $display("Test done: brownout");
      mr_n = 0;
      wait_lvl(rst_n, 0, 600, n);
      chk("manual", n >= MR_DELAY_CYC - 6 && n <= MR_DELAY_CYC + 10, 1);
      chk("manual gate hold", ce_o_n, 0);
      // Button held past the long-pulse time, well before the hold ends
      repeat (MR_CLEAR_CYC + 10 - n) @(posedge clk);
      #1;
      chk("manual clear", {fault_n, warn_n, ce_o_n}, 3'h7);
      mr_n = 1;
      wait_lvl(rst_n, 1, 200, n);
      chk("manual hold", n >= 50 && n <= 62, 1);
      $display("Test done: manual");
      stop_test();
   end
endmodule
